// *** rtl/ftr_pkg.sv ***
// package: register map, reset values and types of the flash timing block
package ftr_pkg;

   // ----------------------------------------
   // register indexes
   // ----------------------------------------
   localparam logic [3:0] IDX_START = 4'h0;
   localparam logic [3:0] IDX_TRAN = 4'h1;
   localparam logic [3:0] IDX_PROG = 4'h2;
   localparam logic [3:0] IDX_PERASE = 4'h3;
   localparam logic [3:0] IDX_MERASE = 4'h4;
   localparam logic [3:0] IDX_END = 4'h5;
   localparam logic [3:0] IDX_MEND = 4'h6;
   localparam logic [3:0] IDX_RCV = 4'h7;
   localparam logic [3:0] IDX_PSR = 4'h8;
   localparam logic [3:0] IDX_FUNC = 4'h9;
   localparam logic [3:0] IDX_PROT = 4'hA;
   localparam logic [3:0] IDX_CODE = 4'hB;
   localparam logic [3:0] IDX_FUNC_MIR = 4'hC;
   localparam logic [3:0] IDX_PROT_MIR = 4'hD;
   localparam logic [3:0] IDX_CODE_MIR = 4'hE;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_START = 8'h18;
   localparam logic [7:0] RST_TRAN = 8'h30;
   localparam logic [7:0] RST_PROG = 8'h16;
   localparam logic [7:0] RST_PERASE = 8'h04;
   localparam logic [7:0] RST_MERASE = 8'hEA;
   localparam logic [7:0] RST_END = 8'h18;
   localparam logic [7:0] RST_MEND = 8'h3C;
   localparam logic [7:0] RST_RCV = 8'h04;
   localparam logic [4:0] RST_PSR = 5'h04;

   // ----------------------------------------
   // field positions and scale shifts
   // ----------------------------------------
   localparam int USB_EN_BIT = 0;
   localparam int BOOT_LSB = 0;
   localparam int BOOT_W = 4;
   localparam int CODE_MID_LSB = 11;
   localparam int PSR_W = 5;
   localparam int PROG_SHIFT = 3;
   localparam int ERASE_SHIFT = 12;
   localparam int MEND_SHIFT = 3;
   localparam int TMR_W = 21;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      OP_PROGRAM,
      OP_PAGE_ERASE,
      OP_MODULE_ERASE,
      OP_NONE
   } ftr_op_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [3:0] addr;
      logic [15:0] wdata;
   } ftr_bus_req_t;

   typedef struct packed {
      logic start_phase;
      logic tran_phase;
      logic prog_pulse;
      logic erase_pulse;
      logic end_phase;
      logic recovery_phase;
   } ftr_phase_t;

endpackage : ftr_pkg

// *** rtl/ftr_phase_timer.sv ***
// file: down counter timing one sequencer phase in prescaler ticks
`timescale 1ns/1ns
module ftr_phase_timer #(
   parameter int W = 21
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   // status
   output logic done
);

   logic [W-1:0] count_reg;

   // ----------------------------------------
   // count down on each tick
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_val;
      end else if (tick && count_reg != '0) begin
         count_reg <= count_reg - W'(1);
      end
   end

   // ----------------------------------------
   // done: last tick of the phase
   // ----------------------------------------
   always_comb begin
      done = tick && (count_reg == W'(1));
   end

endmodule : ftr_phase_timer

// *** rtl/ftr_flash_timing.sv ***
// file: flash timing reload registers, auto-read words and operation sequencer
//
// Summary of operation
// R01: start delay lasts start_delay_count plus one prescaler clocks
// R02: transition interval lasts transition_count plus one prescaler clocks
// R03: program pulse lasts eight times program_pulse_count plus one
// R04: page erase pulse lasts 4096 times page_erase_count plus one
// R05: module erase pulse lasts 4096 times module_erase_count plus one
// R06: end delay lasts end_delay_count plus one prescaler clocks
// R07: module erase end delay lasts eight times module_erase_end_count plus one
// R08: recovery delay of recovery_count plus one between flash accesses
// R09: software must not write timing registers while busy
// R10: timing registers take defaults at reset only if flash idle
// R11: function word copy captured at reset, read only
// R12: usb enable bit zero forces transceiver low power
// R13: protection word copy captured at reset, read only
// R14: each auto-read register mirrored at a second address
// R15: code area start loaded at reset, read only
// R16: code start bits 10:0 read zero
// R17: code start bits 14:11 load inverted boot region select
// R18: code start bit 15 reads zero
// R19: prescaler clock is system clock divided by divisor plus one
// R20: software issues no operation while busy; cpu is stalled
// R21: phases run start, transition, pulse, end, recovery with busy set
// R22: writes to auto-read registers and mirrors are ignored
`timescale 1ns/1ns
module ftr_flash_timing (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // cpu register port
   input wire ftr_pkg::ftr_bus_req_t cpu_req,
   output logic [15:0] cpu_rdata,
   // operation request
   input wire logic op_start,
   input wire ftr_pkg::ftr_op_t op_kind,
   output logic cpu_stall,
   // flash array side
   input wire logic array_busy,
   input wire logic [15:0] info_function_word,
   input wire logic [15:0] info_protection_word,
   output ftr_pkg::ftr_phase_t phase,
   output logic flash_busy_flag,
   // system outputs
   output logic usb_xcvr_low_power,
   output logic [15:0] code_area_start_out
);

   typedef enum {
      ST_IDLE,
      ST_START,
      ST_TRAN,
      ST_PULSE,
      ST_END,
      ST_MEND,
      ST_RECOVER
   } ftr_state_t;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0] start_delay_reload_reg;
   logic [7:0] transition_time_reload_reg;
   logic [7:0] program_pulse_reload_reg;
   logic [7:0] page_erase_pulse_reload_reg;
   logic [7:0] module_erase_pulse_reload_reg;
   logic [7:0] end_delay_reload_reg;
   logic [7:0] module_erase_end_reload_reg;
   logic [7:0] recovery_delay_reload_reg;
   logic [ftr_pkg::PSR_W-1:0] prescaler_divisor_reg;
   logic [15:0] function_word_copy_reg;
   logic [15:0] protection_word_copy_reg;
   logic [15:0] code_area_start_reg;
   logic [ftr_pkg::PSR_W-1:0] presc_cnt_reg;
   logic presc_tick;
   ftr_state_t state_reg;
   ftr_state_t state_next;
   ftr_pkg::ftr_op_t op_reg;
   logic tmr_load;
   logic [ftr_pkg::TMR_W-1:0] tmr_val;
   logic tmr_done;
   logic wr_en;
   logic [15:0] rdata_next;
   logic [15:0] code_start_next;
   logic [ftr_pkg::TMR_W-1:0] start_len;
   logic [ftr_pkg::TMR_W-1:0] tran_len;
   logic [ftr_pkg::TMR_W-1:0] pulse_len;
   logic [ftr_pkg::TMR_W-1:0] end_len;
   logic [ftr_pkg::TMR_W-1:0] mend_len;
   logic [ftr_pkg::TMR_W-1:0] rcv_len;

   assign wr_en = cpu_req.sel && cpu_req.wr;

   // ----------------------------------------
   // timing reload registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         if (!array_busy) begin // R10
            start_delay_reload_reg <= ftr_pkg::RST_START;
            transition_time_reload_reg <= ftr_pkg::RST_TRAN;
            program_pulse_reload_reg <= ftr_pkg::RST_PROG;
            page_erase_pulse_reload_reg <= ftr_pkg::RST_PERASE;
            module_erase_pulse_reload_reg <= ftr_pkg::RST_MERASE;
            end_delay_reload_reg <= ftr_pkg::RST_END;
            module_erase_end_reload_reg <= ftr_pkg::RST_MEND;
            recovery_delay_reload_reg <= ftr_pkg::RST_RCV;
            prescaler_divisor_reg <= ftr_pkg::RST_PSR;
         end
      end else if (wr_en) begin
         case (cpu_req.addr)
            ftr_pkg::IDX_START: start_delay_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_TRAN: transition_time_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_PROG: program_pulse_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_PERASE: page_erase_pulse_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_MERASE: module_erase_pulse_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_END: end_delay_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_MEND: module_erase_end_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_RCV: recovery_delay_reload_reg <= cpu_req.wdata[7:0];
            ftr_pkg::IDX_PSR: prescaler_divisor_reg <= cpu_req.wdata[ftr_pkg::PSR_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // auto-read words, loaded during reset
   // ----------------------------------------
   always_comb begin
      code_start_next = 16'h0000; // R16 R18
      code_start_next[ftr_pkg::CODE_MID_LSB +: ftr_pkg::BOOT_W] =
         ~info_protection_word[ftr_pkg::BOOT_LSB +: ftr_pkg::BOOT_W]; // R17
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         function_word_copy_reg <= info_function_word; // R11
         protection_word_copy_reg <= info_protection_word; // R13
         code_area_start_reg <= code_start_next; // R15
      end
   end

   // ----------------------------------------
   // read mux, registered
   // ----------------------------------------
   always_comb begin
      rdata_next = 16'h0000;
      case (cpu_req.addr)
         ftr_pkg::IDX_START: rdata_next = {8'h00, start_delay_reload_reg};
         ftr_pkg::IDX_TRAN: rdata_next = {8'h00, transition_time_reload_reg};
         ftr_pkg::IDX_PROG: rdata_next = {8'h00, program_pulse_reload_reg};
         ftr_pkg::IDX_PERASE: rdata_next = {8'h00, page_erase_pulse_reload_reg};
         ftr_pkg::IDX_MERASE: rdata_next = {8'h00, module_erase_pulse_reload_reg};
         ftr_pkg::IDX_END: rdata_next = {8'h00, end_delay_reload_reg};
         ftr_pkg::IDX_MEND: rdata_next = {8'h00, module_erase_end_reload_reg};
         ftr_pkg::IDX_RCV: rdata_next = {8'h00, recovery_delay_reload_reg};
         ftr_pkg::IDX_PSR: rdata_next = {11'h000, prescaler_divisor_reg};
         ftr_pkg::IDX_FUNC,
         ftr_pkg::IDX_FUNC_MIR: rdata_next = function_word_copy_reg; // R14
         ftr_pkg::IDX_PROT,
         ftr_pkg::IDX_PROT_MIR: rdata_next = protection_word_copy_reg; // R14
         ftr_pkg::IDX_CODE,
         ftr_pkg::IDX_CODE_MIR: rdata_next = code_area_start_reg; // R14
         default: rdata_next = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpu_rdata <= 16'h0000;
      end else if (cpu_req.sel && !cpu_req.wr) begin
         cpu_rdata <= rdata_next;
      end
   end

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         presc_cnt_reg <= '0;
      end else if (state_reg == ST_IDLE || presc_cnt_reg == prescaler_divisor_reg) begin
         presc_cnt_reg <= '0; // R19
      end else begin
         presc_cnt_reg <= presc_cnt_reg + ftr_pkg::PSR_W'(1);
      end
   end

   assign presc_tick = (state_reg != ST_IDLE) && (presc_cnt_reg == prescaler_divisor_reg);

   // ----------------------------------------
   // phase lengths in prescaler ticks
   // ----------------------------------------
   always_comb begin
      start_len = ftr_pkg::TMR_W'(start_delay_reload_reg) + 21'h000001; // R01
      tran_len = ftr_pkg::TMR_W'(transition_time_reload_reg) + 21'h000001; // R02
      case (op_reg)
         ftr_pkg::OP_PROGRAM: begin
            pulse_len = (ftr_pkg::TMR_W'(program_pulse_reload_reg) + 21'h000001)
               << ftr_pkg::PROG_SHIFT; // R03
         end
         ftr_pkg::OP_PAGE_ERASE: begin
            pulse_len = (ftr_pkg::TMR_W'(page_erase_pulse_reload_reg) + 21'h000001)
               << ftr_pkg::ERASE_SHIFT; // R04
         end
         default: begin
            pulse_len = (ftr_pkg::TMR_W'(module_erase_pulse_reload_reg) + 21'h000001)
               << ftr_pkg::ERASE_SHIFT; // R05
         end
      endcase
      end_len = ftr_pkg::TMR_W'(end_delay_reload_reg) + 21'h000001; // R06
      mend_len = (ftr_pkg::TMR_W'(module_erase_end_reload_reg) + 21'h000001)
         << ftr_pkg::MEND_SHIFT; // R07
      rcv_len = ftr_pkg::TMR_W'(recovery_delay_reload_reg) + 21'h000001; // R08
   end

   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_reg)
         ST_IDLE: begin
            if (op_start && op_kind != ftr_pkg::OP_NONE) begin
               state_next = ST_START;
               tmr_load = 1'b1;
               tmr_val = start_len;
            end
         end
         ST_START: begin
            if (tmr_done) begin // R21
               state_next = ST_TRAN;
               tmr_load = 1'b1;
               tmr_val = tran_len;
            end
         end
         ST_TRAN: begin
            if (tmr_done) begin // R21
               state_next = ST_PULSE;
               tmr_load = 1'b1;
               tmr_val = pulse_len;
            end
         end
         ST_PULSE: begin
            if (tmr_done) begin // R21
               tmr_load = 1'b1;
               if (op_reg == ftr_pkg::OP_MODULE_ERASE) begin
                  state_next = ST_MEND;
                  tmr_val = mend_len;
               end else begin
                  state_next = ST_END;
                  tmr_val = end_len;
               end
            end
         end
         ST_END,
         ST_MEND: begin
            if (tmr_done) begin // R21
               state_next = ST_RECOVER;
               tmr_load = 1'b1;
               tmr_val = rcv_len;
            end
         end
         ST_RECOVER: begin
            if (tmr_done) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         op_reg <= ftr_pkg::OP_NONE;
      end else if (state_reg == ST_IDLE && op_start) begin
         op_reg <= op_kind;
      end
   end

   ftr_phase_timer #(
      .W(ftr_pkg::TMR_W)
   ) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .load_val(tmr_val),
      .tick(presc_tick),
      .done(tmr_done)
   );

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flash_busy_flag <= 1'b0;
      end else begin
         flash_busy_flag <= (state_next != ST_IDLE); // R21
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         phase <= '0;
      end else begin
         phase.start_phase <= (state_next == ST_START);
         phase.tran_phase <= (state_next == ST_TRAN);
         phase.prog_pulse <= (state_next == ST_PULSE) && (op_reg == ftr_pkg::OP_PROGRAM);
         phase.erase_pulse <= (state_next == ST_PULSE) && (op_reg != ftr_pkg::OP_PROGRAM);
         phase.end_phase <= (state_next == ST_END) || (state_next == ST_MEND);
         phase.recovery_phase <= (state_next == ST_RECOVER); // R08
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= (op_start && state_reg != ST_IDLE)
            || (cpu_stall && state_next != ST_IDLE); // R20
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         usb_xcvr_low_power <= ~info_function_word[ftr_pkg::USB_EN_BIT]; // R12
      end else begin
         usb_xcvr_low_power <= ~function_word_copy_reg[ftr_pkg::USB_EN_BIT]; // R12
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         code_area_start_out <= code_start_next; // R15
      end else begin
         code_area_start_out <= code_area_start_reg;
      end
   end

   // writes to indexes 9..14 fall to the default branch and are dropped (R22)

endmodule : ftr_flash_timing

// *** testbench/ftr_flash_timing_asserts.sv ***
// checker: port properties of the flash timing block
`timescale 1ns/1ns
module ftr_flash_timing_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // cpu side
   input wire ftr_pkg::ftr_bus_req_t cpu_req,
   input wire logic [15:0] cpu_rdata,
   input wire logic op_start,
   input wire ftr_pkg::ftr_op_t op_kind,
   input wire logic cpu_stall,
   // flash side
   input wire logic [15:0] info_function_word,
   input wire logic [15:0] info_protection_word,
   input wire ftr_pkg::ftr_phase_t phase,
   input wire logic flash_busy_flag,
   input wire logic usb_xcvr_low_power,
   input wire logic [15:0] code_area_start_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   property p_accept;
      op_start && op_kind != ftr_pkg::OP_NONE && !flash_busy_flag
         |=> flash_busy_flag && phase.start_phase;
   endproperty
   a_accept: assert property (p_accept) else $error("operation not started");
   property p_stall;
      op_start && flash_busy_flag |=> cpu_stall;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall while busy");
   property p_stall_hold;
      cpu_stall && flash_busy_flag |=> cpu_stall || !flash_busy_flag;
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("stall released while busy");
   property p_onehot;
      flash_busy_flag |-> $onehot(phase);
   endproperty
   a_onehot: assert property (p_onehot) else $error("phase not one-hot");
   property p_idle;
      !flash_busy_flag |-> phase == 6'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("phase active while idle");
   property p_tran;
      $fell(phase.start_phase) && flash_busy_flag |-> phase.tran_phase;
   endproperty
   a_tran: assert property (p_tran) else $error("start not followed by transition");
   property p_pulse;
      $rose(phase.prog_pulse) |-> phase.prog_pulse [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("program pulse too short");
   property p_rcv;
      $fell(phase.recovery_phase) |-> !flash_busy_flag;
   endproperty
   a_rcv: assert property (p_rcv) else $error("busy after recovery");
   property p_code;
      $rose(rst_n) |-> code_area_start_out ==
         {1'b0, ~$past(info_protection_word[3:0]), 11'h000};
   endproperty
   a_code: assert property (p_code) else $error("code start word wrong");
   property p_usb;
      $rose(rst_n) |-> usb_xcvr_low_power == !$past(info_function_word[0]);
   endproperty
   a_usb: assert property (p_usb) else $error("transceiver power wrong");
   property p_ro;
      $past(rst_n) |-> $stable(code_area_start_out);
   endproperty
   a_ro: assert property (p_ro) else $error("code start changed");
   property p_rd;
      cpu_req.sel && !cpu_req.wr && (cpu_req.addr == ftr_pkg::IDX_CODE ||
         cpu_req.addr == ftr_pkg::IDX_CODE_MIR) |=> cpu_rdata == code_area_start_out;
   endproperty
   a_rd: assert property (p_rd) else $error("code start read wrong");
endmodule : ftr_flash_timing_asserts

bind ftr_flash_timing ftr_flash_timing_asserts u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
   .op_start(op_start), .op_kind(op_kind), .cpu_stall(cpu_stall),
   .info_function_word(info_function_word), .info_protection_word(info_protection_word),
   .phase(phase), .flash_busy_flag(flash_busy_flag),
   .usb_xcvr_low_power(usb_xcvr_low_power), .code_area_start_out(code_area_start_out)
);

// *** testbench/ftr_flash_array_model.sv ***
// partner: flash array busy level and information block words
`timescale 1ns/1ns
module ftr_flash_array_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // bench control
   input wire logic force_busy,
   input wire logic [15:0] func_word,
   input wire logic [15:0] prot_word,
   // block side
   input wire ftr_pkg::ftr_phase_t phase,
   output logic array_busy,
   output logic [15:0] info_function_word,
   output logic [15:0] info_protection_word
);
   logic pulse_reg = 1'b0;
   always_ff @(posedge core_clk) begin
      pulse_reg <= rst_n & (phase.prog_pulse | phase.erase_pulse);
   end
   // busy while pulsing or held busy across a reset
   assign array_busy = force_busy | pulse_reg;
   // words valid only while sampled in reset, inverted otherwise
   assign info_function_word = rst_n ? ~func_word : func_word;
   assign info_protection_word = rst_n ? ~prot_word : prot_word;
endmodule : ftr_flash_array_model

// *** testbench/tb_top.sv ***
// testbench: reset values, register access and timed operations
`timescale 1ns/1ns
module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   ftr_pkg::ftr_bus_req_t cpu_req = '0;
   logic [15:0] cpu_rdata;
   logic op_start = 1'b0;
   ftr_pkg::ftr_op_t op_kind = ftr_pkg::OP_PROGRAM;
   logic cpu_stall, array_busy, flash_busy_flag, usb_xcvr_low_power;
   logic [15:0] info_function_word, info_protection_word, code_area_start_out;
   ftr_pkg::ftr_phase_t phase;
   logic force_busy = 1'b0;
   logic [15:0] func_word = 16'h0000;
   logic [15:0] prot_word = 16'h0000;
   logic [15:0] rd;
   logic [7:0] regv [0:8];
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int i;
   always #20 core_clk = ~core_clk;
   ftr_flash_timing dut (.core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .op_start(op_start), .op_kind(op_kind), .cpu_stall(cpu_stall),
      .array_busy(array_busy), .info_function_word(info_function_word),
      .info_protection_word(info_protection_word), .phase(phase),
      .flash_busy_flag(flash_busy_flag), .usb_xcvr_low_power(usb_xcvr_low_power),
      .code_area_start_out(code_area_start_out));
   ftr_flash_array_model u_flash (.core_clk(core_clk), .rst_n(rst_n),
      .force_busy(force_busy), .func_word(func_word), .prot_word(prot_word), .phase(phase),
      .array_busy(array_busy), .info_function_word(info_function_word),
      .info_protection_word(info_protection_word));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic reg_acc(input logic wr, input int a, input logic [15:0] wd);
      @(negedge core_clk);
      cpu_req = {1'b1, wr, 4'(a), wd};
      @(negedge core_clk);
      cpu_req.sel = 1'b0;
      rd = cpu_rdata;
   endtask : reg_acc
   task automatic do_reset();
      func_word = 16'($urandom());
      prot_word = 16'($urandom());
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
   endtask : do_reset
   function automatic logic [15:0] exp_rd(input int a);
      case (a)
         0: exp_rd = {8'h00, ftr_pkg::RST_START};
         5: exp_rd = {8'h00, ftr_pkg::RST_END};
         1: exp_rd = {8'h00, ftr_pkg::RST_TRAN};
         2: exp_rd = {8'h00, ftr_pkg::RST_PROG};
         3: exp_rd = {8'h00, ftr_pkg::RST_PERASE};
         7: exp_rd = {8'h00, ftr_pkg::RST_RCV};
         4: exp_rd = {8'h00, ftr_pkg::RST_MERASE};
         6: exp_rd = {8'h00, ftr_pkg::RST_MEND};
         8: exp_rd = {11'h000, ftr_pkg::RST_PSR};
         9, 12: exp_rd = func_word;
         10, 13: exp_rd = prot_word;
         11, 14: exp_rd = {1'b0, ~prot_word[3:0], 11'h000};
         default: exp_rd = 16'h0000;
      endcase
   endfunction : exp_rd
   task automatic check_ro();
      for (int a = 9; a < 16; a++) begin
         reg_acc(1'b0, a, 16'h0000);
         chk(rd, exp_rd(a));
      end
      chk(usb_xcvr_low_power, !func_word[0]);
      chk(code_area_start_out, exp_rd(11));
   endtask : check_ro
   task automatic run_op(input ftr_pkg::ftr_op_t kind);
      int c [0:5];
      int d;
      c = '{default: 0};
      d = regv[8] + 1;
      @(negedge core_clk);
      op_kind = kind;
      op_start = 1'b1;
      @(negedge core_clk);
      op_start = 1'b0;
      for (int n = 0; n < 20000 && flash_busy_flag === 1'b1; n++) begin
         for (int m = 0; m < 6; m++) c[m] += phase[m];
         op_start = (n == 2);
         if (n >= 3) begin
            chk(cpu_stall, 1'b1);
         end
         @(negedge core_clk);
      end
      chk(cpu_stall, 1'b0);
      chk(c[5], (regv[0] + 1) * d);
      chk(c[4], (regv[1] + 1) * d);
      if (kind == ftr_pkg::OP_PROGRAM) begin
         chk(c[3], 8 * (regv[2] + 1) * d);
      end else begin
         chk(c[2], 4096 * (regv[kind == ftr_pkg::OP_PAGE_ERASE ? 3 : 4] + 1) * d);
      end
      if (kind == ftr_pkg::OP_MODULE_ERASE) begin
         chk(c[1], 8 * (regv[6] + 1) * d);
      end else begin
         chk(c[1], (regv[5] + 1) * d);
      end
      chk(c[0], (regv[7] + 1) * d);
   endtask : run_op
   // ----------------------------------------
   // timeout and main sequence
   // ----------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h19C1));
      do_reset();
      for (i = 0; i < 9; i++) begin
         reg_acc(1'b0, i, 16'h0000);
         chk(rd, exp_rd(i));
      end
      check_ro();
      for (i = 9; i < 16; i++) reg_acc(1'b1, i, 16'($urandom()));
      check_ro();
      reg_acc(1'b1, 8, 16'hFFFF);
      reg_acc(1'b0, 8, 16'h0000);
      chk(rd, 16'h001F);
      reg_acc(1'b1, 4, 16'hFFFF);
      reg_acc(1'b0, 4, 16'h0000);
      chk(rd, 16'h00FF);
      for (int p = 0; p < 2; p++) begin
         for (i = 0; i < 9; i++) begin
            regv[i] = (i == 8) ? 8'(p) : 8'($urandom_range(i == 3 || i == 4 ? 1 - p : 3));
            reg_acc(1'b1, i, {8'($urandom()), regv[i]});
            reg_acc(1'b0, i, 16'h0000);
            chk(rd, {8'h00, regv[i]});
         end
         // no register writes while busy
         for (int k = 0; k < 3; k++) run_op(ftr_pkg::ftr_op_t'(k));
      end
      @(negedge core_clk);
      op_kind = ftr_pkg::OP_NONE;
      op_start = 1'b1;
      @(negedge core_clk);
      op_start = 1'b0;
      chk(flash_busy_flag, 1'b0);
      reg_acc(1'b1, 0, 16'h005A);
      force_busy = 1'b1;
      do_reset();
      reg_acc(1'b0, 0, 16'h0000);
      chk(rd, 16'h005A);
      force_busy = 1'b0;
      do_reset();
      reg_acc(1'b0, 0, 16'h0000);
      chk(rd, exp_rd(0));
      check_ro();
      final_report();
   end
endmodule : tb_top
